// ### logic/mmd_consts.svh
// Constants for the memory map and bank decode block
// How it works
// - Program counter is 13 bits, spanning 8k words of 14 bits.
// - Only program words 0000h to 07FFh are physically present.
// - Program addresses above 2k wrap; only low 11 bits used.
// - After any reset, fetch starts at program word 0000h.
// - A taken interrupt sends fetch to program word 0004h.
// - Data memory has two banks, each with special and general locations.
// - Lowest 32 locations of each bank are special-function registers.
// - 20h-7Fh in bank 0 and A0h-BFh in bank 1 are static RAM.
// - Bank 1 F0h-FFh reach the same storage as bank 0 70h-7Fh.
// - Unimplemented locations read zero; writes to them store nothing.
// - One status bank bit picks bank 0 or bank 1 for direct access.
// - Data reachable by direct address or through the indirect pointer.
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_PC_W 13
`define MMD_PROG_AW 11
`define MMD_INSN_W 14
`define MMD_RESET_VEC 13'h0000
`define MMD_INT_VEC 13'h0004
`define MMD_DADDR_W 8
`define MMD_FILE_W 7
`define MMD_SFR_LAST 5'h1f
`define MMD_B0_GPR_LO 8'h20
`define MMD_B0_GPR_HI 8'h7f
`define MMD_B1_GPR_LO 8'ha0
`define MMD_B1_GPR_HI 8'hbf
`define MMD_SHARE_LO 8'hf0
`define MMD_SHARE_HI 8'hff
`define MMD_RAM_DEPTH 128
`define MMD_RAM_AW 7
`define MMD_B1_RAM_BASE 7'h60
`endif

// ### logic/mmd_pkg.sv
// Types shared by the memory map and bank decode block
package mmd_pkg;
  typedef enum logic [1:0] {
    MMD_REGION_NONE = 2'h0,
    MMD_REGION_SFR = 2'h1,
    MMD_REGION_RAM = 2'h3
  } mmd_region_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_dreq_s;
  typedef struct packed {
    mmd_region_e region;
    logic [6:0] ram_index;
    logic [7:0] full_addr;
  } mmd_decode_s;
endpackage

// ### logic/mmd_ram.sv
// General-purpose data storage with write enable and registered read
module mmd_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // Synchronous write and read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ### logic/mmd_memory_map.sv
// Program fetch address and data bank decode for the core
`include "mmd_consts.svh"
module mmd_memory_map
  import mmd_pkg::*;
#(
  parameter int RAM_DEPTH = `MMD_RAM_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`MMD_PC_W-1:0] pc_next,
  input wire logic pc_load,
  input wire logic int_taken,
  input wire logic bank_select_bit,
  input wire logic [`MMD_DADDR_W-1:0] indirect_pointer_register,
  input wire mmd_dreq_s dreq,
  input wire logic [7:0] sfr_rdata,
  output logic [`MMD_PC_W-1:0] pc_out,
  output logic [`MMD_PROG_AW-1:0] prog_addr,
  output logic sfr_we,
  output logic [4:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [7:0] data_rdata,
  output logic data_rvalid,
  output logic [1:0] region_out
);
  // Decode an 8-bit data address into region and storage index
  function automatic mmd_decode_s decode(input logic [7:0] a);
    mmd_decode_s d;
    d.full_addr = a;
    d.ram_index = 7'h00;
    d.region = MMD_REGION_NONE;
    if (a[6:0] <= {2'h0, `MMD_SFR_LAST}) begin
      d.region = MMD_REGION_SFR;
    end else if (a >= `MMD_B0_GPR_LO && a <= `MMD_B0_GPR_HI) begin
      d.region = MMD_REGION_RAM;
      d.ram_index = a[6:0] - 7'h20;
    end else if (a >= `MMD_B1_GPR_LO && a <= `MMD_B1_GPR_HI) begin
      d.region = MMD_REGION_RAM;
      d.ram_index = `MMD_B1_RAM_BASE + (a[6:0] - 7'h20);
    end else if (a >= `MMD_SHARE_LO) begin
      d.region = MMD_REGION_RAM;
      d.ram_index = a[6:0] - 7'h20;
    end
    return d;
  endfunction

  wire [7:0] direct_addr = {bank_select_bit, dreq.addr[6:0]};
  // direct or indirect path; bank bit chooses bank on the direct path only
  wire [7:0] eff_addr = dreq.indirect ? indirect_pointer_register
                                      : direct_addr;
  wire mmd_decode_s dec = decode(eff_addr);
  wire is_ram = dreq.valid && dec.region == MMD_REGION_RAM;
  wire is_sfr = dreq.valid && dec.region == MMD_REGION_SFR;
  wire ram_we = is_ram && dreq.write;
  wire [7:0] ram_rdata;

  mmd_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(`MMD_RAM_AW)
  ) u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(dec.ram_index),
    .wdata(dreq.wdata),
    .rdata(ram_rdata)
  );

  // wrap to low 11 bits; only 2k present
  wire [`MMD_PROG_AW-1:0] prog_next = pc_next[`MMD_PROG_AW-1:0];

  // Program counter and fetch address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_out <= `MMD_RESET_VEC;
      prog_addr <= `MMD_PROG_AW'(`MMD_RESET_VEC);
    end else if (int_taken) begin
      pc_out <= `MMD_INT_VEC;
      prog_addr <= `MMD_PROG_AW'(`MMD_INT_VEC);
    end else if (pc_load) begin
      pc_out <= pc_next;
      prog_addr <= prog_next;
    end
  end

  // Special area strobes passed to the register owners
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sfr_we <= 1'b0;
      sfr_addr <= 5'h00;
      sfr_wdata <= 8'h00;
    end else begin
      sfr_we <= is_sfr && dreq.write;
      sfr_addr <= eff_addr[4:0];
      sfr_wdata <= dreq.wdata;
    end
  end

  // Read tracking: region decoded in the previous cycle, whether or not a request was valid
  mmd_region_e rd_region_reg;
  logic rd_pending_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_region_reg <= MMD_REGION_NONE;
      rd_pending_reg <= 1'b0;
    end else begin
      rd_region_reg <= dec.region;
      rd_pending_reg <= dreq.valid && !dreq.write;
    end
  end

  // unimplemented reads as zero; both banks served
  wire [7:0] rdata_next =
    (rd_region_reg == MMD_REGION_RAM) ? ram_rdata :
    (rd_region_reg == MMD_REGION_SFR) ? sfr_rdata : 8'h00;

  // Registered read answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_rdata <= 8'h00;
      data_rvalid <= 1'b0;
      region_out <= 2'h0;
    end else begin
      data_rdata <= rd_pending_reg ? rdata_next : 8'h00;
      data_rvalid <= rd_pending_reg;
      region_out <= rd_region_reg;
    end
  end
endmodule

// ### tb/mmd_chk.sv
// Checker for fetch address and data bank decode
module mmd_chk
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [12:0] pc_next,
  input wire logic pc_load,
  input wire logic int_taken,
  input wire logic bank_select_bit,
  input wire logic [7:0] indirect_pointer_register,
  input wire mmd_dreq_s dreq,
  input wire logic [12:0] pc_out,
  input wire logic [10:0] prog_addr,
  input wire logic sfr_we,
  input wire logic [4:0] sfr_addr,
  input wire logic [7:0] data_rdata,
  input wire logic [1:0] region_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Effective address and request kinds
  wire logic [7:0] da = dreq.indirect ? indirect_pointer_register
    : {bank_select_bit, dreq.addr[6:0]};
  wire logic rd = dreq.valid & ~dreq.write;
  wire logic wr = dreq.valid & dreq.write;
  sequence s_rd_none; rd && da inside {[8'hc0:8'hef]}; endsequence
  sequence s_rd_sfr; rd && da[6:5] == 2'h0; endsequence
  a_pc_wrap: assert property (prog_addr == pc_out[10:0])
    else $error("pc wrap");
  a_reset_vec: assert property ($rose(resetn) |-> pc_out == 13'h0)
    else $error("reset vector");
  a_int_vec: assert property (int_taken |=> pc_out == 13'h0004)
    else $error("int vector");
  a_pc_load: assert property (pc_load && !int_taken |=>
    pc_out == $past(pc_next)) else $error("pc load");
  a_sfr_write: assert property (wr && da[6:5] == 2'h0 |=>
    sfr_we && sfr_addr == $past(da[4:0])) else $error("sfr write");
  a_rd_none: assert property (s_rd_none |-> ##2
    data_rdata == 8'h0 && region_out == 2'h0) else $error("unimp read");
  a_rd_sfr: assert property (s_rd_sfr |-> ##2 region_out == 2'h1)
    else $error("sfr region");
  a_rd_ram: assert property (rd && da[6:5] != 2'h0 &&
    !(da inside {[8'hc0:8'hef]}) |-> ##2 region_out == 2'h3)
    else $error("ram region");
endmodule

// ### tb/mmd_sfr_model.sv
// Special-register stub facing the data port
module mmd_sfr_model (
  input wire logic clk,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Last written byte is read back
  initial sfr_rdata = 8'h00;
  always @(posedge clk) if (sfr_we) sfr_rdata <= sfr_wdata;
endmodule

// ### tb/tb_top.sv
// Testbench for the memory map and bank decode block
module tb_top
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, pc_load = 1'b0, int_taken = 1'b0;
  logic bank_select_bit = 1'b0, sfr_we, data_rvalid;
  logic [12:0] pc_next = 13'h0, pc_out;
  logic [7:0] indirect_pointer_register = 8'h0, sfr_rdata;
  logic [7:0] sfr_wdata, data_rdata;
  logic [10:0] prog_addr;
  logic [4:0] sfr_addr;
  logic [1:0] region_out;
  mmd_dreq_s dreq = '0;
  int n_mismatch = 0, check_count = 0;
  always #2 clk = ~clk;
  mmd_memory_map uut (.clk, .resetn, .pc_next, .pc_load, .int_taken,
    .bank_select_bit, .indirect_pointer_register, .dreq, .sfr_rdata,
    .pc_out, .prog_addr, .sfr_we, .sfr_addr, .sfr_wdata, .data_rdata,
    .data_rvalid, .region_out);
  mmd_sfr_model u_sfr (.clk, .sfr_we, .sfr_wdata, .sfr_rdata);
  task automatic chk(input logic [12:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // drives bank bit, pointer and a one-cycle request
  task automatic acc(input logic w, ind, bank, input logic [7:0] a, wd);
    @(posedge clk);
    bank_select_bit <= bank;
    indirect_pointer_register <= a;
    dreq <= '{1'b1, w, ind, a, wd};
    @(posedge clk);
    dreq.valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic i, b, input logic [7:0] a, d,
    input logic [1:0] r);
    acc(1'b0, i, b, a, 8'h0);
    chk({2'h0, data_rvalid, region_out, data_rdata}, {2'h0, 1'b1, r, d});
  endtask
  // Vectors, load and wrap of the fetch address
  task automatic t_pc;
    chk(pc_out, 13'h0);
    @(posedge clk);
    pc_next <= 13'h1abc;
    pc_load <= 1'b1;
    @(posedge clk);
    int_taken <= 1'b1;
    #1 chk({2'h0, prog_addr}, 13'h2bc);
    chk(pc_out, 13'h1abc);
    @(posedge clk);
    {pc_load, int_taken} <= 2'b0;
    #1 chk(pc_out, 13'h0004);
  endtask
  // Top end of each bank's RAM, shared window, indirect path
  task automatic t_ram;
    acc(1'b1, 1'b0, 1'b0, 8'h7f, 8'ha5);
    acc(1'b1, 1'b0, 1'b1, 8'h3f, 8'h3c);
    acc(1'b1, 1'b0, 1'b1, 8'h75, 8'h77);
    rd(1'b0, 1'b0, 8'h7f, 8'ha5, 2'h3);
    rd(1'b0, 1'b1, 8'h3f, 8'h3c, 2'h3);
    rd(1'b0, 1'b0, 8'h75, 8'h77, 2'h3);
    rd(1'b1, 1'b0, 8'hbf, 8'h3c, 2'h3);
  endtask
  // Unimplemented space and special area
  task automatic t_other;
    acc(1'b1, 1'b0, 1'b1, 8'h40, 8'hff);
    rd(1'b0, 1'b1, 8'h40, 8'h00, 2'h0);
    acc(1'b1, 1'b1, 1'b0, 8'h83, 8'h9e);
    rd(1'b0, 1'b1, 8'h03, 8'h9e, 2'h1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    t_pc;
    t_ram;
    t_other;
    tally_and_finish;
  end
  // Watchdog against a hung run
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind mmd_memory_map mmd_chk u_chk (.clk, .resetn, .pc_next, .pc_load,
  .int_taken, .bank_select_bit, .indirect_pointer_register, .dreq,
  .pc_out, .prog_addr, .sfr_we, .sfr_addr, .data_rdata, .region_out);
